// ===== core/bpm_cfg.svh
// Register map, field positions, codes and timing for the buck mode control
`ifndef BPM_CFG_SVH
`define BPM_CFG_SVH
`define BPM_AW 12
`define BPM_OFF_MASK 12'h00C
`define BPM_OFF_STAT 12'h010
`define BPM_OFF_CTL 12'h014
`define BPM_OFF_ACT 12'h100
`define BPM_OFF_SLP 12'h104
`define BPM_OFF_BCFG 12'h500
`define BPM_OFF_BURST 12'h504
`define BPM_RST_CTL 3'h7
`define BPM_RST_ACT 32'h3F10_0E15
`define BPM_RST_SLP 32'h0002_1D04
`define BPM_RST_BCFG 32'h0000_0000
`define BPM_RST_BURST 32'h0140_0000
`define BPM_DS_LSB 0
`define BPM_LVL_LSB 10
`define BPM_LVD_BIT 16
`define BPM_HVD_BIT 17
`define BPM_LPOFF_BIT 20
`define BPM_HVSEL_BIT 0
`define BPM_ON_BIT 0
`define BPM_LVL_1V25 2'h0
`define BPM_LVL_1V35 2'h1
`define BPM_LVL_2V5 2'h2
`define BPM_LVL_1V8 2'h3
`define BPM_DS_PULSE 2'h0
`define BPM_DS_LOW 2'h1
`define BPM_DS_NORM 2'h2
`define BPM_STAT_BUSY 0
`define BPM_EV_LSB 1
`define BPM_EV_W 3
`define BPM_SETTLE_NS 2000
`define BPM_CLK_MHZ 20
`endif

// ===== core/bpm_pkg.sv
// Types shared by the buck mode control design
package bpm_pkg;
  typedef enum logic [2:0] {
    PM_ACTIVE, PM_SLEEP, PM_DSLEEP, PM_PDOWN, PM_DPD
  } bpm_pmode_t;
  typedef enum logic [1:0] {ST_ACTIVE, ST_ENTER, ST_LOW} bpm_state_t;
endpackage : bpm_pkg

// ===== core/bpm_settle_timer.sv
// Transition settle timer that drives the busy flag
`timescale 1ns/10ps
`include "bpm_cfg.svh"
module bpm_settle_timer import bpm_pkg::*; #(
  parameter int unsigned CYC = 40
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic start,
  output logic busy,
  output logic done
);
  initial begin
    if (CYC < 1 || CYC > 65535) $error("bpm_settle_timer: bad CYC");
  end
  logic [15:0] cnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_r <= 16'h0000;
    else if (start) cnt_r <= 16'(CYC);
    else if (cnt_r != 16'h0000) cnt_r <= cnt_r - 16'h0001;
  end
  assign busy = (cnt_r != 16'h0000);
  assign done = (cnt_r == 16'h0001) && !start;
endmodule : bpm_settle_timer

// ===== core/bpm_apply_decode.sv
// Chooses the applied buck level and drive from mode and settings
`timescale 1ns/10ps
`include "bpm_cfg.svh"
module bpm_apply_decode import bpm_pkg::*; (
  // Mode context
  input wire bpm_pmode_t pm,
  input wire logic st_low,
  input wire logic sys_quiet,
  input wire logic buck_on,
  // Settings
  input wire logic [31:0] act_cfg,
  input wire logic [31:0] slp_cfg,
  // Applied result
  output logic on,
  output logic [1:0] lvl,
  output logic normal,
  output logic low,
  output logic pulsed,
  output logic bad
);
  logic [31:0] sel;
  logic [1:0] ds;
  logic deep;
  always_comb begin
    deep = (pm == PM_DSLEEP) || (pm == PM_PDOWN);
    sel = (pm == PM_ACTIVE) ? act_cfg : slp_cfg; // see [R1]
    ds = sel[`BPM_DS_LSB +: 2];
    lvl = sel[`BPM_LVL_LSB +: 2]; // see [R10]
    bad = 1'b0;
    normal = 1'b0;
    low = 1'b0;
    pulsed = 1'b0;
    on = buck_on && (pm != PM_DPD); // see [R2] [R14]
    if (deep && slp_cfg[`BPM_LPOFF_BIT]) on = 1'b0;
    if (ds == `BPM_DS_LOW) begin
      low = 1'b1; // see [R12] [R13]
    end else if (ds == `BPM_DS_NORM) begin
      normal = 1'b1;
    end else if (ds == `BPM_DS_PULSE && pm != PM_ACTIVE) begin
      if (pm == PM_SLEEP) bad = 1'b1; // see [R4]
      if (slp_cfg[`BPM_LVD_BIT] || slp_cfg[`BPM_HVD_BIT]) bad = 1'b1;
      if (deep && st_low && sys_quiet && !bad) pulsed = 1'b1; // see [R16]
      else normal = 1'b1;
    end else begin
      bad = 1'b1;
      normal = 1'b1;
    end
    if (lvl == `BPM_LVL_2V5 && !normal) begin
      lvl = `BPM_LVL_1V8; // see [R6]
      bad = 1'b1;
    end
    if (!on) begin
      normal = 1'b0; // see [R3]
      low = 1'b0;
      pulsed = 1'b0;
    end
  end
endmodule : bpm_apply_decode

// ===== core/bpm_ctrl.sv
// Buck power mode control: APB registers, mode sequencing and outputs
// Function
// [R1] Active settings apply in Active mode, sleep settings in low-power modes.
// [R2] Entering Deep Power Down forces the buck converter off.
// [R3] Normal and low drive exist in all modes except Deep Power Down.
// [R4] Pulsed refresh takes effect only in Deep Sleep and Power Down.
// [R5] Software may turn buck off in deep modes if wakeup domains unaffected.
// [R6] The 2.5 V level is allowed only with normal drive strength.
// [R7] Software disables both voltage detectors before selecting pulsed refresh.
// [R8] Any level or drive change sets busy until the transition completes.
// [R9] Software polls busy until zero after changing level or drive.
// [R10] Level codes: 00 1.25 V, 01 1.35 V, 10 2.5 V, 11 1.8 V.
// [R11] Software sets high voltage select only with level code 10.
// [R12] Active drive: 01 low, 10 normal, 00 and 11 reserved.
// [R13] Sleep drive: 00 pulsed refresh, 01 low, 10 normal, 11 reserved.
// [R14] Buck-on bit turns converter on or off; resets on; write-once.
// [R15] Software clears buck-on when bypassed, after checking supplied domains.
// [R16] Pulsed refresh waits for all domains low, controller low, core asleep.
// [R17] Automatic mode entry or exit changing level or drive also sets busy.
`timescale 1ns/10ps
`include "bpm_cfg.svh"
module bpm_ctrl import bpm_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`BPM_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // System power mode
  input wire logic [2:0] pm_req,
  input wire logic domains_lp,
  input wire logic cpu_asleep,
  // Buck converter control
  output logic buck_on_o,
  output logic [1:0] buck_level_o,
  output logic buck_normal_o,
  output logic buck_low_o,
  output logic buck_pulsed_o,
  output logic high_voltage_select_o,
  output logic [2:0] pm_cur_o,
  // Status
  output logic busy_o,
  output logic irq_o
);
  localparam int unsigned SETTLE_CYC =
    (`BPM_SETTLE_NS * `BPM_CLK_MHZ + 999) / 1000;
  localparam int CHK_BUSY_MAX = 64;

  bpm_pmode_t pm_r;
  bpm_state_t st_r;
  logic [2:0] ctl_r;
  logic ctl_lock_r;
  logic [31:0] act_r;
  logic [31:0] slp_r;
  logic [31:0] bcfg_r;
  logic [31:0] burst_r;
  logic [`BPM_EV_W-1:0] ev_r;
  logic [`BPM_EV_W-1:0] mask_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic bad_r;

  // APB decode, taken in the setup cycle so read data is registered
  logic setup;
  logic wr;
  logic hit;
  logic [31:0] rd_nxt;
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;

  always_comb begin
    hit = 1'b1;
    rd_nxt = 32'h0000_0000;
    if (paddr == `BPM_OFF_CTL) begin
      rd_nxt[2:0] = ctl_r;
    end else if (paddr == `BPM_OFF_ACT) begin
      rd_nxt = act_r;
    end else if (paddr == `BPM_OFF_SLP) begin
      rd_nxt = slp_r;
    end else if (paddr == `BPM_OFF_BCFG) begin
      rd_nxt = bcfg_r;
    end else if (paddr == `BPM_OFF_BURST) begin
      rd_nxt = burst_r;
    end else if (paddr == `BPM_OFF_STAT) begin
      rd_nxt[`BPM_STAT_BUSY] = busy_o;
      rd_nxt[`BPM_EV_LSB +: `BPM_EV_W] = ev_r;
    end else if (paddr == `BPM_OFF_MASK) begin
      rd_nxt[`BPM_EV_LSB +: `BPM_EV_W] = mask_r;
    end else begin
      hit = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
      pslverr_r <= !hit;
    end
  end
  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = pslverr_r;

  // Regulator control: first write locks the register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= `BPM_RST_CTL;
      ctl_lock_r <= 1'b0;
    end else if (wr && !pslverr_r && paddr == `BPM_OFF_CTL && !ctl_lock_r) begin
      ctl_r <= pwdata[2:0]; // see [R14]
      ctl_lock_r <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_r <= `BPM_RST_ACT;
      slp_r <= `BPM_RST_SLP;
      bcfg_r <= `BPM_RST_BCFG;
      burst_r <= `BPM_RST_BURST;
      mask_r <= '0;
    end else if (wr && !pslverr_r) begin
      if (paddr == `BPM_OFF_ACT) act_r <= pwdata;
      if (paddr == `BPM_OFF_SLP) slp_r <= pwdata;
      if (paddr == `BPM_OFF_BCFG) bcfg_r <= pwdata;
      if (paddr == `BPM_OFF_BURST) burst_r <= pwdata;
      if (paddr == `BPM_OFF_MASK) begin
        mask_r <= pwdata[`BPM_EV_LSB +: `BPM_EV_W];
      end
    end
  end

  // Power mode tracking; codes above Deep Power Down are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pm_r <= PM_ACTIVE;
    else if (pm_req <= 3'(PM_DPD)) pm_r <= bpm_pmode_t'(pm_req);
  end

  logic busy;
  logic done;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_ACTIVE;
    end else begin
      case (st_r)
        ST_ACTIVE: if (pm_r != PM_ACTIVE) st_r <= ST_ENTER;
        ST_ENTER: begin
          if (pm_r == PM_ACTIVE) st_r <= ST_ACTIVE;
          else if (!busy) st_r <= ST_LOW;
        end
        ST_LOW: if (pm_r == PM_ACTIVE) st_r <= ST_ACTIVE;
        default: st_r <= ST_ACTIVE;
      endcase
    end
  end

  logic d_on;
  logic [1:0] d_lvl;
  logic d_norm;
  logic d_low;
  logic d_pulse;
  logic d_bad;
  bpm_apply_decode u_dec (
    .pm(pm_r),
    .st_low(st_r == ST_LOW),
    .sys_quiet(domains_lp && cpu_asleep),
    .buck_on(ctl_r[`BPM_ON_BIT]),
    .act_cfg(act_r),
    .slp_cfg(slp_r),
    .on(d_on),
    .lvl(d_lvl),
    .normal(d_norm),
    .low(d_low),
    .pulsed(d_pulse),
    .bad(d_bad)
  );

  // Applied outputs; any change except high voltage select restarts the settle timer
  logic chg;
  assign chg = (d_on != buck_on_o) || (d_lvl != buck_level_o) ||
               (d_norm != buck_normal_o) || (d_low != buck_low_o) ||
               (d_pulse != buck_pulsed_o);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buck_on_o <= 1'b1;
      buck_level_o <= `BPM_LVL_1V8;
      buck_normal_o <= 1'b0;
      buck_low_o <= 1'b1;
      buck_pulsed_o <= 1'b0;
      high_voltage_select_o <= 1'b0;
      bad_r <= 1'b0;
    end else begin
      buck_on_o <= d_on;
      buck_level_o <= d_lvl;
      buck_normal_o <= d_norm;
      buck_low_o <= d_low;
      buck_pulsed_o <= d_pulse;
      high_voltage_select_o <= bcfg_r[`BPM_HVSEL_BIT];
      bad_r <= d_bad;
    end
  end

  bpm_settle_timer #(.CYC(SETTLE_CYC)) u_tmr (
    .pclk(pclk),
    .presetn(presetn),
    .start(chg), // see [R8] [R17]
    .busy(busy),
    .done(done)
  );
  assign busy_o = busy || chg;
  assign pm_cur_o = pm_r;

  // Sticky events: done, bad setting, mode change; set wins over clear
  logic [`BPM_EV_W-1:0] ev_set;
  logic [`BPM_EV_W-1:0] ev_clr;
  assign ev_set = {pm_req != pm_r && pm_req <= 3'(PM_DPD),
                   d_bad && !bad_r, done};
  assign ev_clr = (wr && paddr == `BPM_OFF_STAT) ?
                  pwdata[`BPM_EV_LSB +: `BPM_EV_W] : '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ev_r <= '0;
    else ev_r <= (ev_r & ~ev_clr) | ev_set;
  end
  assign irq_o = |(ev_r & mask_r);

  chk_dpd_off: assert property (@(posedge pclk) disable iff (!presetn)
    pm_r == PM_DPD |=> !buck_on_o) else $error("buck on in DPD"); // see [R2]
  chk_dpd_drive: assert property (@(posedge pclk) disable iff (!presetn)
    pm_r == PM_DPD |=> !buck_normal_o && !buck_low_o && !buck_pulsed_o)
    else $error("drive active in DPD"); // see [R3]
  chk_refresh_gate: assert property (@(posedge pclk) disable iff (!presetn)
    buck_pulsed_o |-> $past(st_r == ST_LOW && domains_lp && cpu_asleep &&
    (pm_r == PM_DSLEEP || pm_r == PM_PDOWN)))
    else $error("pulsed refresh outside deep low power"); // see [R4] [R16]
  chk_hv_normal: assert property (@(posedge pclk) disable iff (!presetn)
    buck_on_o && buck_level_o == `BPM_LVL_2V5 |-> buck_normal_o)
    else $error("2.5 V without normal drive"); // see [R6]
  chk_active_level: assert property (@(posedge pclk) disable iff (!presetn)
    pm_r == PM_ACTIVE && act_r[`BPM_LVL_LSB +: 2] != `BPM_LVL_2V5
    |=> buck_level_o == $past(act_r[`BPM_LVL_LSB +: 2]))
    else $error("active level not applied"); // see [R1] [R10]
  chk_active_low: assert property (@(posedge pclk) disable iff (!presetn)
    pm_r == PM_ACTIVE && ctl_r[`BPM_ON_BIT] &&
    act_r[`BPM_DS_LSB +: 2] == `BPM_DS_LOW |=> buck_low_o && !buck_normal_o)
    else $error("active low drive not applied"); // see [R12]
  chk_busy_set: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(buck_level_o) || $changed(buck_low_o) |-> busy_o)
    else $error("change without busy"); // see [R8] [R17]
  chk_busy_end: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(busy_o) |-> ##[1:CHK_BUSY_MAX] !busy_o)
    else $error("busy never clears"); // see [R8]
  chk_ctl_once: assert property (@(posedge pclk) disable iff (!presetn)
    ctl_lock_r |=> $stable(ctl_r))
    else $error("control written twice"); // see [R14]
  chk_sleep_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pm_r == PM_SLEEP |=> !buck_pulsed_o)
    else $error("pulsed refresh in sleep"); // see [R4] [R13]
endmodule : bpm_ctrl

// ===== tb/test_buck_power_mode_control.sv
// Self-checking bench for the buck power mode control block
`timescale 1ns/10ps
`include "bpm_cfg.svh"
module test_buck_power_mode_control;
  import bpm_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [`BPM_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [2:0] pm_req = 3'h0;
  logic domains_lp = 1'b0;
  logic cpu_asleep = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, buck_on_o, buck_normal_o, buck_low_o;
  logic buck_pulsed_o, high_voltage_select_o, busy_o, irq_o;
  logic [1:0] buck_level_o;
  logic [2:0] pm_cur_o;
  logic [31:0] q;
  logic e;
  int bad_count = 0;
  int num_checks = 0;
  logic [11:0] ra [5] = '{`BPM_OFF_CTL, `BPM_OFF_ACT, `BPM_OFF_SLP,
    `BPM_OFF_BCFG, `BPM_OFF_BURST};
  logic [31:0] rv [5] = '{{29'h0, `BPM_RST_CTL}, `BPM_RST_ACT,
    `BPM_RST_SLP, `BPM_RST_BCFG, `BPM_RST_BURST};
  // Active settings table: level, drive code, expected level and drive
  logic [1:0] tl [6] = '{2'h1, 2'h0, 2'h2, 2'h2, 2'h3, 2'h1};
  logic [1:0] td [6] = '{2'h1, 2'h0, 2'h2, 2'h1, 2'h3, 2'h2};
  logic [1:0] el [6] = '{2'h1, 2'h0, 2'h2, 2'h3, 2'h3, 2'h1};
  logic [2:0] ed [6] = '{3'h2, 3'h4, 3'h4, 3'h2, 3'h4, 3'h4};

  always #25 pclk = ~pclk;

  bpm_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pm_req(pm_req),
    .domains_lp(domains_lp), .cpu_asleep(cpu_asleep),
    .buck_on_o(buck_on_o), .buck_level_o(buck_level_o),
    .buck_normal_o(buck_normal_o), .buck_low_o(buck_low_o),
    .buck_pulsed_o(buck_pulsed_o),
    .high_voltage_select_o(high_voltage_select_o), .pm_cur_o(pm_cur_o),
    .busy_o(busy_o), .irq_o(irq_o));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done;
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  // One APB transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Waits for busy to rise (when expected) and then to clear
  task automatic settle(input bit rise);
    int n;
    n = 0;
    if (rise) begin
      while (busy_o !== 1'b1 && n < 8) begin
        @(posedge pclk);
        n++;
      end
      chk(32'(busy_o), 32'h1);
    end
    // Software view: poll the status busy bit until it reads zero
    n = 0;
    q = 32'h1;
    while (q[`BPM_STAT_BUSY] !== 1'b0 && n < 100) begin
      apb(1'b0, `BPM_OFF_STAT, '0);
      n++;
    end
    chk(32'(q[`BPM_STAT_BUSY]), 32'h0);
    chk(32'(busy_o), 32'h0);
    @(posedge pclk);
  endtask : settle

  task automatic outs(input logic [1:0] l, input logic [2:0] d);
    chk(32'({buck_level_o, buck_normal_o, buck_low_o, buck_pulsed_o}),
        32'({l, d}));
  endtask : outs

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ra[i], '0);
      chk(q, rv[i]);
    end
    chk(32'(buck_on_o), 32'h1);
    outs(2'h3, 3'h2);
    apb(1'b0, 12'h200, '0);
    chk({q[31:1], e}, 32'h1);
    $display("registers done");
    apb(1'b1, `BPM_OFF_BCFG, 32'h1);
    @(posedge pclk);
    chk(32'(high_voltage_select_o), 32'h1);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, `BPM_OFF_BCFG, 32'(tl[i] == `BPM_LVL_2V5));
      apb(1'b1, `BPM_OFF_ACT, (`BPM_RST_ACT & ~32'hC03) |
          (32'(tl[i]) << 10) | 32'(td[i]));
      settle(1'b1);
      outs(el[i], ed[i]);
      chk(32'(high_voltage_select_o), 32'(tl[i] == `BPM_LVL_2V5));
    end
    $display("active settings done");
    apb(1'b0, `BPM_OFF_STAT, '0);
    chk(q & 32'h4, 32'h4);
    apb(1'b1, `BPM_OFF_MASK, 32'h4);
    @(posedge pclk);
    chk(32'(irq_o), 32'h1);
    apb(1'b1, `BPM_OFF_MASK, 32'h0);
    @(posedge pclk);
    chk(32'(irq_o), 32'h0);
    apb(1'b1, `BPM_OFF_STAT, 32'hE);
    apb(1'b1, `BPM_OFF_MASK, 32'hE);
    @(posedge pclk);
    chk(32'(irq_o), 32'h0);
    apb(1'b0, `BPM_OFF_STAT, '0);
    chk(q, 32'h0);
    $display("interrupt done");
    pm_req <= 3'h1;
    settle(1'b1);
    outs(2'h3, 3'h4);
    // Detectors are off in this value before pulsed refresh is used
    apb(1'b1, `BPM_OFF_SLP, 32'h0000_1D04);
    domains_lp <= 1'b1;
    cpu_asleep <= 1'b1;
    pm_req <= 3'h2;
    for (int n = 0; n < 300 && buck_pulsed_o !== 1'b1; n++) begin
      @(posedge pclk);
    end
    outs(2'h3, 3'h1);
    pm_req <= 3'h0;
    settle(1'b1);
    outs(2'h1, 3'h4);
    domains_lp <= 1'b0;
    cpu_asleep <= 1'b0;
    apb(1'b1, `BPM_OFF_SLP, 32'h0000_1901);
    pm_req <= 3'h1;
    settle(1'b1);
    outs(2'h3, 3'h2);
    pm_req <= 3'h4;
    settle(1'b1);
    chk(32'({buck_on_o, buck_normal_o, buck_low_o, buck_pulsed_o}),
        32'h0);
    pm_req <= 3'h0;
    settle(1'b1);
    chk(32'(buck_on_o), 32'h1);
    // Optional converter off in Power Down, wakeup domains assumed elsewhere
    apb(1'b1, `BPM_OFF_SLP, 32'h0010_1D05);
    pm_req <= 3'h3;
    settle(1'b1);
    chk(32'({buck_on_o, buck_normal_o, buck_low_o, buck_pulsed_o}),
        32'h0);
    pm_req <= 3'h0;
    settle(1'b1);
    outs(2'h1, 3'h4);
    chk(32'(buck_on_o), 32'h1);
    $display("power modes done");
    // Supplied domains are idle here, so the converter may be cleared
    apb(1'b1, `BPM_OFF_CTL, 32'h0);
    settle(1'b0);
    chk(32'(buck_on_o), 32'h0);
    apb(1'b1, `BPM_OFF_CTL, 32'h7);
    apb(1'b0, `BPM_OFF_CTL, '0);
    chk(q, 32'h0);
    chk(32'(buck_on_o), 32'h0);
    $display("buck enable done");
    test_done();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    test_done();
  end
endmodule : test_buck_power_mode_control
